// ### pmcc_top.sv
// Power and mode command decoder: sleep, regulator settings, current sense
module pmcc_top
   import pmcc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = pmcc_pkg::PMCC_DEV_ADDR_DEF
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic analog_en_o,
   output logic reg_en_o,
   output logic reg_vsel_o,
   output logic isense_mode_o,
   output logic sleep_o,
   output logic input_sel_seen_o
);
   import pmcc_pkg::*;

   typedef struct packed {
      pmcc_state_type st;
      logic [1:0] reg_set;
      logic sleep;
      logic isense;
      logic analog_en;
      logic reg_en;
      logic insel_pulse;
      logic ack;
      logic load;
   } pmcc_top_state_type;

   pmcc_top_state_type cur;
   pmcc_top_state_type next_cur;
   pmcc_byte_if bif ();
   logic sda_oe_raw;
   logic is_insel;
   logic cmd_known;
   logic read_dir;

   pmcc_link u_link (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_raw),
      .bus(bif.link)
   );

   always_comb begin
      is_insel = 1'b0;
      case (bif.rx_byte)
         PMCC_CMD_INSEL_0, PMCC_CMD_INSEL_1, PMCC_CMD_INSEL_2, PMCC_CMD_INSEL_3,
         PMCC_CMD_INSEL_4, PMCC_CMD_INSEL_5, PMCC_CMD_INSEL_6, PMCC_CMD_INSEL_7: begin
            is_insel = 1'b1;
         end
         default: begin
            is_insel = 1'b0;
         end
      endcase
   end

   assign read_dir = bif.rx_byte[0];

   always_comb begin
      next_cur = cur;
      next_cur.insel_pulse = 1'b0;
      // Held in flops: the link asks for them an SCL phase after the byte ends
      bif.ack_req = cur.ack;
      bif.tx_byte = {6'h00, cur.reg_set};
      bif.tx_load = cur.load;
      cmd_known = 1'b0;
      if (bif.start) begin
         next_cur.st = PMCC_ST_DEVADR;
         next_cur.ack = 1'b0;
         next_cur.load = 1'b0;
      end else if (bif.stop) begin
         next_cur.st = PMCC_ST_IDLE;
      end else if (bif.byte_valid) begin
         next_cur.ack = 1'b0;
         next_cur.load = 1'b0;
         case (cur.st)
            PMCC_ST_DEVADR: begin
               if (bif.rx_byte[7:1] == DEV_ADDR) begin
                  next_cur.ack = 1'b1;
                  // The retained settings byte is the read answer, awake or asleep
                  next_cur.load = read_dir;
                  next_cur.st = read_dir ? PMCC_ST_READ : PMCC_ST_CMD;
               end else begin
                  next_cur.st = PMCC_ST_IGNORE;
               end
            end
            PMCC_ST_CMD: begin
               if (bif.rx_byte == PMCC_CMD_WAKE) begin
                  cmd_known = 1'b1;
                  next_cur.sleep = 1'b0;
                  next_cur.st = PMCC_ST_IGNORE;
               end else if (bif.rx_byte == PMCC_CMD_REG_SET) begin
                  cmd_known = 1'b1;
                  next_cur.st = PMCC_ST_PARAM;
               end else if (!cur.sleep) begin
                  if (bif.rx_byte == PMCC_CMD_SLEEP) begin
                     cmd_known = 1'b1;
                     next_cur.sleep = 1'b1;
                  end else if (bif.rx_byte == PMCC_CMD_ISENSE) begin
                     cmd_known = 1'b1;
                     next_cur.isense = 1'b1;
                  end else if (is_insel) begin
                     // Input selection itself lives elsewhere; here it ends sensing and pulses input_sel_seen_o
                     cmd_known = 1'b1;
                     next_cur.isense = 1'b0;
                     next_cur.insel_pulse = 1'b1;
                  end
                  next_cur.st = PMCC_ST_IGNORE;
               end else begin
                  next_cur.st = PMCC_ST_IGNORE;
               end
               next_cur.ack = cmd_known;
            end
            PMCC_ST_PARAM: begin
               next_cur.ack = 1'b1;
               next_cur.reg_set[PMCC_VSEL_BIT] = bif.rx_byte[PMCC_VSEL_BIT];
               next_cur.reg_set[PMCC_SLEEP_OFF_BIT] = bif.rx_byte[PMCC_SLEEP_OFF_BIT];
               // Further bytes before stop are not acknowledged
               next_cur.st = PMCC_ST_IGNORE;
            end
            default: begin
               next_cur.st = cur.st;
            end
         endcase
      end else if (bif.master_ack_valid && cur.st == PMCC_ST_READ) begin
         next_cur.load = bif.master_ack;
      end
      next_cur.analog_en = ~next_cur.sleep;
      next_cur.reg_en = ~next_cur.sleep | ~next_cur.reg_set[PMCC_SLEEP_OFF_BIT];
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cur.st <= PMCC_ST_IDLE;
         cur.reg_set <= PMCC_REG_SET_RESET;
         cur.sleep <= PMCC_SLEEP_RESET;
         cur.isense <= PMCC_ISENSE_RESET;
         cur.analog_en <= 1'b1;
         cur.reg_en <= 1'b1;
         cur.insel_pulse <= 1'b0;
         cur.ack <= 1'b0;
         cur.load <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // Open-drain pin: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_raw;
   assign analog_en_o = cur.analog_en;
   assign reg_en_o = cur.reg_en;
   assign reg_vsel_o = cur.reg_set[PMCC_VSEL_BIT];
   assign isense_mode_o = cur.isense;
   assign sleep_o = cur.sleep;
   assign input_sel_seen_o = cur.insel_pulse;
endmodule

// ### pmcc_pkg.sv
// Package: constants and types for the power and mode command block
package pmcc_pkg;
   localparam logic [6:0] PMCC_DEV_ADDR_DEF = 7'h48;  // Arbitrary default bus address
   localparam logic [7:0] PMCC_CMD_WAKE = 8'h04;
   localparam logic [7:0] PMCC_CMD_SLEEP = 8'h05;
   localparam logic [7:0] PMCC_CMD_REG_SET = 8'h07;
   localparam logic [7:0] PMCC_CMD_ISENSE = 8'h08;
   localparam logic [7:0] PMCC_CMD_INSEL_0 = 8'h10;
   localparam logic [7:0] PMCC_CMD_INSEL_1 = 8'h12;
   localparam logic [7:0] PMCC_CMD_INSEL_2 = 8'h14;
   localparam logic [7:0] PMCC_CMD_INSEL_3 = 8'h15;
   localparam logic [7:0] PMCC_CMD_INSEL_4 = 8'h18;
   localparam logic [7:0] PMCC_CMD_INSEL_5 = 8'h1a;
   localparam logic [7:0] PMCC_CMD_INSEL_6 = 8'h1c;
   localparam logic [7:0] PMCC_CMD_INSEL_7 = 8'h1e;
   localparam int PMCC_VSEL_BIT = 0;
   localparam int PMCC_SLEEP_OFF_BIT = 1;
   localparam logic [1:0] PMCC_REG_SET_RESET = 2'h0;
   localparam logic PMCC_SLEEP_RESET = 1'b0;
   localparam logic PMCC_ISENSE_RESET = 1'b0;

   typedef enum logic [2:0] {
      PMCC_ST_IDLE = 3'b000,
      PMCC_ST_DEVADR = 3'b001,
      PMCC_ST_CMD = 3'b010,
      PMCC_ST_PARAM = 3'b011,
      PMCC_ST_READ = 3'b100,
      PMCC_ST_IGNORE = 3'b101
   } pmcc_state_type;
endpackage

// ### pmcc_byte_if.sv
// Interface: byte stream between the serial link front end and the decoder
interface pmcc_byte_if;
   logic start;
   logic stop;
   logic byte_valid;
   logic [7:0] rx_byte;
   logic ack_req;
   logic [7:0] tx_byte;
   logic tx_load;
   logic master_ack;
   logic master_ack_valid;

   modport link (output start, output stop, output byte_valid, output rx_byte,
                 input ack_req, input tx_byte, input tx_load,
                 output master_ack, output master_ack_valid);
   modport dec (input start, input stop, input byte_valid, input rx_byte,
                output ack_req, output tx_byte, output tx_load,
                input master_ack, input master_ack_valid);
endinterface

// ### pmcc_sync.sv
// Two-stage synchroniser for the serial pins
module pmcc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } pmcc_sync_state_type;

   pmcc_sync_state_type cur;
   pmcc_sync_state_type next_cur;

   always_comb begin
      next_cur.meta = async_i;
      next_cur.sync = cur.meta;
   end

   // Idle bus lines are high
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cur <= '1;
      end else begin
         cur <= next_cur;
      end
   end

   assign sync_o = cur.sync;
endmodule

// ### pmcc_link.sv
// Serial two-wire slave front end: start, stop, byte shift, acknowledge
module pmcc_link (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   pmcc_byte_if.link bus
);
   typedef enum logic [1:0] {
      PMCC_LK_IDLE = 2'b00,
      PMCC_LK_SHIFT = 2'b01,
      PMCC_LK_ACK = 2'b10,
      PMCC_LK_MACK = 2'b11
   } pmcc_lk_type;

   typedef struct packed {
      logic scl_d;
      logic sda_d;
      pmcc_lk_type mode;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic tx_mode;
      logic oe;
      logic ack_fall;
   } pmcc_link_state_type;

   pmcc_link_state_type cur;
   pmcc_link_state_type next_cur;
   logic [1:0] pins;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   pmcc_sync #(.WIDTH(2)) u_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i({scl_i, sda_i}),
      .sync_o(pins)
   );

   assign scl = pins[1];
   assign sda = pins[0];
   assign scl_rise = scl & ~cur.scl_d;
   assign scl_fall = ~scl & cur.scl_d;
   assign start_det = scl & cur.scl_d & cur.sda_d & ~sda;
   assign stop_det = scl & cur.scl_d & ~cur.sda_d & sda;

   always_comb begin
      next_cur = cur;
      next_cur.scl_d = scl;
      next_cur.sda_d = sda;
      bus.start = start_det;
      bus.stop = stop_det;
      bus.byte_valid = 1'b0;
      bus.rx_byte = cur.sh;
      bus.master_ack = 1'b0;
      bus.master_ack_valid = 1'b0;
      if (start_det) begin
         next_cur.mode = PMCC_LK_SHIFT;
         next_cur.cnt = 4'h0;
         next_cur.tx_mode = 1'b0;
         next_cur.oe = 1'b0;
      end else if (stop_det) begin
         next_cur.mode = PMCC_LK_IDLE;
         next_cur.oe = 1'b0;
      end else begin
         case (cur.mode)
            PMCC_LK_SHIFT: begin
               if (cur.tx_mode && scl_fall) begin
                  next_cur.oe = ~cur.sh[7];
               end
               if (scl_rise) begin
                  next_cur.sh = cur.tx_mode ? {cur.sh[6:0], 1'b0} : {cur.sh[6:0], sda};
                  next_cur.cnt = cur.cnt + 4'h1;
                  if (cur.cnt == 4'h7) begin
                     next_cur.mode = cur.tx_mode ? PMCC_LK_MACK : PMCC_LK_ACK;
                     next_cur.ack_fall = 1'b0;
                     if (!cur.tx_mode) begin
                        bus.byte_valid = 1'b1;
                        bus.rx_byte = {cur.sh[6:0], sda};
                     end
                  end
               end
            end
            PMCC_LK_ACK: begin
               // Drive the low acknowledge from the eighth fall to the ninth fall
               if (scl_fall) begin
                  if (!cur.ack_fall) begin
                     next_cur.ack_fall = 1'b1;
                     next_cur.oe = bus.ack_req;
                     if (!bus.ack_req) begin
                        next_cur.mode = PMCC_LK_IDLE;
                     end
                  end else begin
                     next_cur.oe = 1'b0;
                     next_cur.cnt = 4'h0;
                     next_cur.mode = PMCC_LK_SHIFT;
                     next_cur.tx_mode = bus.tx_load;
                     if (bus.tx_load) begin
                        next_cur.sh = bus.tx_byte;
                        next_cur.oe = ~bus.tx_byte[7];
                     end
                  end
               end
            end
            PMCC_LK_MACK: begin
               if (scl_fall && !cur.ack_fall) begin
                  next_cur.ack_fall = 1'b1;
                  next_cur.oe = 1'b0;
               end else if (scl_rise && cur.ack_fall) begin
                  bus.master_ack = ~sda;
                  bus.master_ack_valid = 1'b1;
                  // A not-acknowledge ends the read; the host follows with stop
                  next_cur.mode = sda ? PMCC_LK_IDLE : PMCC_LK_ACK;
               end
            end
            default: begin
               next_cur.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cur <= '{scl_d: 1'b1, sda_d: 1'b1, mode: PMCC_LK_IDLE, cnt: 4'h0,
                  sh: 8'h00, tx_mode: 1'b0, oe: 1'b0, ack_fall: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign sda_oe_o = cur.oe;
endmodule

// ### pmcc_top_sva.sv
// Checker: port-level properties of the power and mode command block
module pmcc_top_sva (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic analog_en_o,
   input wire logic reg_en_o,
   input wire logic reg_vsel_o,
   input wire logic isense_mode_o,
   input wire logic sleep_o,
   input wire logic input_sel_seen_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   sequence sel_pulse;
      input_sel_seen_o ##1 !input_sel_seen_o;
   endsequence
   sequence settled_sleep;
      sleep_o ##1 sleep_o;
   endsequence
   reset_volt_a: assert property ($fell(srst_i) |-> !reg_vsel_o && reg_en_o)
      else $error("settings wrong after reset");
   reset_awake_a: assert property ($fell(srst_i) |-> !sleep_o && analog_en_o && !isense_mode_o)
      else $error("not awake after reset");
   awake_reg_on_a: assert property (!sleep_o && !$past(sleep_o) |-> reg_en_o)
      else $error("regulator off while awake");
   sleep_analog_a: assert property (settled_sleep |-> !analog_en_o)
      else $error("analog on during sleep");
   sleep_keeps_a: assert property ($changed(sleep_o) |-> $stable(reg_vsel_o))
      else $error("setting moved with sleep change");
   vsel_timing_a: assert property ($changed(reg_vsel_o) |-> $past(scl_i, 2))
      else $error("voltage select moved off a byte");
   sel_pulse_a: assert property (input_sel_seen_o |-> !sleep_o ##0 sel_pulse)
      else $error("input select pulse wrong");
   isense_clear_a: assert property ($fell(isense_mode_o) |-> input_sel_seen_o || $past(input_sel_seen_o))
      else $error("current sense cleared without select");
   ack_low_a: assert property ($rose(sda_oe_o) |-> !scl_i && !sda_o)
      else $error("ack driven at wrong time");
endmodule

bind pmcc_top pmcc_top_sva chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .analog_en_o(analog_en_o),
   .reg_en_o(reg_en_o), .reg_vsel_o(reg_vsel_o), .isense_mode_o(isense_mode_o),
   .sleep_o(sleep_o), .input_sel_seen_o(input_sel_seen_o));

// ### pmcc_host_model.sv
// Host model: two-wire bus master that writes commands and reads settings
module pmcc_host_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] res;
   event res_ev;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Eight cycles each phase keeps the device's edge detector comfortable
   task automatic clk_bit(input logic b, output logic s);
      sda_o = b;
      w(4);
      scl_o = 1'b1;
      w(4);
      s = sda_i;
      w(4);
      scl_o = 1'b0;
      w(4);
   endtask
   task automatic start();
      sda_o = 1'b1;
      scl_o = 1'b1;
      w(8);
      sda_o = 1'b0;
      w(8);
      scl_o = 1'b0;
      w(4);
   endtask
   task automatic stop();
      sda_o = 1'b0;
      w(4);
      scl_o = 1'b1;
      w(8);
      sda_o = 1'b1;
      w(8);
   endtask
   // Ninth bit released: write sees the ack, read ends with a not-ack
   task automatic xfer(input logic [7:0] b, input logic rd);
      logic s;
      logic [7:0] v;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(rd ? 1'b1 : b[i], s);
         v[i] = s;
      end
      clk_bit(1'b1, s);
      res = rd ? v : {7'h0, ~s};
      ->res_ev;
   endtask
endmodule

// ### power_mode_command_ctrl_tb.sv
// Testbench: serial commands in, power and mode outputs checked
module power_mode_command_ctrl_tb import pmcc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
      $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sda_oe, sda_d, h_sda, scl;
   logic analog_en, reg_en, vsel, isense, sleep, sel_seen;
   int pulses = 0;
   wire sda_w = h_sda & (sda_oe ? sda_d : 1'b1);
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 74;
   logic [7:0] p, e;
   logic [7:0] exp_q[$];
   logic [7:0] sel [8] = '{PMCC_CMD_INSEL_0, PMCC_CMD_INSEL_1, PMCC_CMD_INSEL_2,
      PMCC_CMD_INSEL_3, PMCC_CMD_INSEL_4, PMCC_CMD_INSEL_5, PMCC_CMD_INSEL_6, PMCC_CMD_INSEL_7};
   pmcc_host_model h (.clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(h_sda));
   pmcc_top dut (.sys_clk_i(sys_clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .analog_en_o(analog_en), .reg_en_o(reg_en), .reg_vsel_o(vsel),
      .isense_mode_o(isense), .sleep_o(sleep), .input_sel_seen_o(sel_seen));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic st(input logic [4:0] x);
      `CHK({analog_en, reg_en, vsel, isense, sleep}, x)
   endtask
   // Expected acks are queued before each byte; the monitor pairs them up
   task automatic cmd(input logic [7:0] c, input logic ac, input logic np,
                      input logic [7:0] pv, input logic ap);
      h.start();
      exp_q.push_back(8'h01);
      h.xfer({PMCC_DEV_ADDR_DEF, 1'b0}, 1'b0);
      exp_q.push_back({7'h0, ac});
      h.xfer(c, 1'b0);
      if (np) begin
         exp_q.push_back({7'h0, ap});
         h.xfer(pv, 1'b0);
      end
      h.stop();
      h.w(8);
   endtask
   task automatic rd(input logic [7:0] x);
      h.start();
      exp_q.push_back(8'h01);
      h.xfer({PMCC_DEV_ADDR_DEF, 1'b1}, 1'b0);
      exp_q.push_back(x);
      h.xfer(8'hff, 1'b1);
      h.stop();
      h.w(8);
   endtask
   initial begin
      forever begin
         @(h.res_ev);
         e = exp_q.pop_front();
         `CHK(h.res, e)
      end
   end
   // Sampled mid-cycle so the one-cycle pulse is seen settled
   always @(negedge sys_clk) begin
      if (sel_seen === 1'b1) begin
         pulses++;
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(negedge sys_clk);
      srst = 1'b0;
      h.w(4);
      st(5'b11000);
      for (int i = 0; i < 4; i++) begin
         p = 8'($random(seed));
         cmd(PMCC_CMD_REG_SET, 1'b1, 1'b1, p, 1'b1);
         st({2'b11, p[0], 2'b00});
         rd({6'h0, p[1:0]});
      end
      cmd(PMCC_CMD_REG_SET, 1'b1, 1'b1, 8'hfe, 1'b1);
      foreach (sel[i]) begin
         cmd(PMCC_CMD_ISENSE, 1'b1, 1'b1, 8'h5a, 1'b0);
         st(5'b11010);
         cmd(sel[i], 1'b1, 1'b0, 8'h00, 1'b0);
         st(5'b11000);
      end
      cmd(PMCC_CMD_SLEEP, 1'b1, 1'b0, 8'h00, 1'b0);
      st(5'b00001);
      rd(8'h02);
      cmd(PMCC_CMD_ISENSE, 1'b0, 1'b0, 8'h00, 1'b0);
      cmd(sel[0], 1'b0, 1'b0, 8'h00, 1'b0);
      cmd(PMCC_CMD_REG_SET, 1'b1, 1'b1, 8'h01, 1'b1);
      st(5'b01101);
      cmd(PMCC_CMD_WAKE, 1'b1, 1'b0, 8'h00, 1'b0);
      st(5'b11100);
      `CHK(pulses, 8)
      `CHK(exp_q.size(), 0)
      tally_and_finish();
   end
endmodule
